// ==== hw/gzc_pkg.sv ====
// shared constants, reply carrier and helpers for the zero-calibration command block
// assumes a byte-wide serial front end outside; all values are plain binary
package gzc_pkg;
  // framing and command characters
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_DOT   = 8'h2E;
  localparam logic [7:0] CH_0     = 8'h30;
  localparam logic [7:0] CH_9     = 8'h39;
  localparam logic [7:0] CMD_FAIR = 8'h47;
  localparam logic [7:0] CMD_NITR = 8'h55;
  localparam logic [7:0] CMD_FRCE = 8'h75;
  localparam logic [7:0] CMD_KNWN = 8'h58;
  localparam logic [7:0] CMD_PARM = 8'h50;
  localparam logic [7:0] CMD_AZI  = 8'h40;
  localparam logic [7:0] CMD_ALTS = 8'h53;
  localparam logic [7:0] CMD_ALTQ = 8'h73;
  // parameter indices for the two-byte reference words
  localparam logic [16:0] IDX_BG_HI = 17'h0_0008;
  localparam logic [16:0] IDX_BG_LO = 17'h0_0009;
  localparam logic [16:0] IDX_FA_HI = 17'h0_000A;
  localparam logic [16:0] IDX_FA_LO = 17'h0_000B;
  localparam logic [16:0] BYTE_MAX  = 17'h0_00FF;
  // reset values and ranges
  localparam logic [15:0] REF_DEF   = 16'h0190;
  localparam logic [15:0] MULT_DEF  = 16'h0001;
  localparam logic [16:0] ALT_DEF   = 17'h0_2000;
  localparam logic [16:0] VAL_MAX   = 17'h1_0000;
  localparam logic [16:0] ZERO_MAX  = 17'h0_FFFF;
  localparam logic [8:0]  AZ_INIT_DEF = 9'h00A;
  localparam logic [8:0]  AZ_REG_DEF  = 9'h050;
  localparam logic [16:0] AZ_MIN    = 17'h0_0001;
  localparam logic [16:0] AZ_MAX    = 17'h0_017B;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_MULT   = 8'h04;
  localparam logic [7:0] REG_ZERO   = 8'h08;
  localparam logic [7:0] REG_AZ     = 8'h0C;
  localparam logic [7:0] REG_ALT    = 8'h10;
  localparam logic [7:0] REG_REFS   = 8'h14;
  localparam logic [7:0] REG_BGSC   = 8'h18;
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int AZ_EN_BIT      = 31;

  typedef enum logic [1:0] {FMT_PAD5, FMT_TENTHS, FMT_ZERO} gzc_fmt_t;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [1:0]  nf;
    gzc_fmt_t    fmt;
    logic [16:0] f0;
    logic [16:0] f1;
  } gzc_reply_t;

  // reference concentration times the configured multiplier
  function automatic logic [32:0] scale(input logic [16:0] v, input logic [15:0] m);
    scale = 33'(v) * 33'(m);
  endfunction : scale

  function automatic logic [7:0] asc(input int d);
    asc = CH_0 + 8'(d % 10);
  endfunction : asc
endpackage : gzc_pkg

// ==== hw/gzc_reply_tx.sv ====
// reply line builder and byte serialiser
// assumes the consumer takes a byte on each clock where valid and ready are both high
module gzc_reply_tx (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               load,
  input  wire gzc_pkg::gzc_reply_t reply,
  input  wire logic               tx_ready,
  output logic                    busy,
  output logic [7:0]              tx_data,
  output logic                    tx_valid
);
  import gzc_pkg::*;

  logic [7:0] buf_q    [16];
  logic [7:0] next_buf [16];
  logic [4:0] len;
  logic [4:0] idx;
  logic [4:0] next_len;
  int         n;
  int         v;
  int         ip;

  always_comb begin
    n = 0;
    v = 0;
    ip = 0;
    for (int i = 0; i < 16; i++) begin
      next_buf[i] = 8'h00;
    end
    next_buf[0] = reply.cmd;
    n = 1;
    for (int f = 0; f < 2; f++) begin
      if (f < int'(reply.nf)) begin
        v = (f == 0) ? int'(reply.f0) : int'(reply.f1);
        next_buf[n] = CH_SP;
        n++;
        if (reply.fmt == FMT_ZERO) begin
          next_buf[n] = CH_0;
          n++;
        end else if (reply.fmt == FMT_TENTHS) begin
          // whole days without padding, then one tenth digit
          ip = v / 10;
          if (ip >= 10) begin
            next_buf[n] = asc(ip / 10);
            n++;
          end
          next_buf[n] = asc(ip);
          next_buf[n+1] = CH_DOT;
          next_buf[n+2] = asc(v);
          n = n + 3;
        end else begin
          for (int k = 0; k < 5; k++) begin
            next_buf[n+4-k] = asc(v);
            v = v / 10;
          end
          n = n + 5;
        end
      end
    end
    next_buf[n] = CH_CR;
    next_buf[n+1] = CH_LF;
    next_len = 5'(n + 2);
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      idx <= 5'h00;
      len <= 5'h00;
    end else if (load && !busy) begin
      buf_q <= next_buf;
      len <= next_len;
      tx_data <= next_buf[0];
      tx_valid <= 1'b1;
      idx <= 5'h01;
      busy <= 1'b1;
    end else if (tx_valid && tx_ready) begin
      if (idx == len) begin
        tx_valid <= 1'b0;
        busy <= 1'b0;
      end else begin
        tx_data <= buf_q[idx[3:0]];
        idx <= idx + 5'h01;
      end
    end
  end
endmodule : gzc_reply_tx

// ==== hw/gzc_cmd_core.sv ====
// command line parser and executor for zero-point, reference, auto-zero and altitude settings
// assumes bytes arrive on a valid/ready stream from a uart receiver; replies leave the same way
// registers reached over classic wishbone; raw sensor level arrives on RAW
// Functional notes
// - lines end with CR then LF; LF after CR triggers execution.
// - fresh-air command sets zero from raw level minus scaled fresh reference.
// - nitrogen command sets zero assuming zero gas; replies with value.
// - forced zero command stores its argument as zero and echoes it.
// - known-gas command scales argument by multiplier and sets zero from it.
// - two-byte words are high times 256 plus low.
// - background and fresh-air references are multiplied by multiplier before use.
// - auto-zero enabled at reset, intervals 1.0 and 8.0 days.
// - interval command with lone zero disables auto-zero.
// - bare interval command reports 0 or both intervals.
// - accepted settings are answered with command character and values.
// - altitude set stores 0 to 65536, default 8192.
// - altitude query replies with stored value.
// - sleep mode ignores zero-altering commands.
module gzc_cmd_core (
  input  wire logic        CLK_SYS,
  input  wire logic        RSTN,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic [15:0] RAW,
  input  wire logic [7:0]  RX_DATA,
  input  wire logic        RX_VALID,
  output logic             RX_READY,
  output logic [7:0]       TX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic [15:0]      ZERO_POINT,
  output logic             AZ_ENABLE
);
  import gzc_pkg::*;

  typedef enum {ST_CMD, ST_ARGS, ST_LF, ST_SKIP, ST_EXEC, ST_WAIT} gzc_state_t;

  gzc_state_t  st;
  gzc_state_t  next_st;
  logic [7:0]  cmd;
  logic [1:0]  nargs;
  logic [16:0] acc;
  logic        in_num;
  logic        dot;
  logic [1:0]  frac;
  logic        err;
  logic [16:0] arg0;
  logic [16:0] arg1;
  logic        tok0;
  logic        tok1;
  logic        sleep;
  logic [15:0] mult;
  logic [15:0] bg_ref;
  logic [15:0] fa_ref;
  logic [16:0] alt;
  logic [8:0]  az_init;
  logic [8:0]  az_reg;
  logic        tx_busy;

  // receive path
  wire        rx_take  = RX_VALID && RX_READY;
  wire        is_digit = (RX_DATA >= CH_0) && (RX_DATA <= CH_9);
  wire [20:0] acc_wide = 21'(acc) * 21'd10 + 21'(RX_DATA - CH_0);
  wire        close_f  = in_num && ((RX_DATA == CH_SP) || (RX_DATA == CH_CR));
  wire        tenth_ok = dot && (frac == 2'h1);
  wire        bad_byte = !(is_digit || RX_DATA == CH_SP || RX_DATA == CH_CR
                           || RX_DATA == CH_DOT);

  // execution decode
  wire        n0      = (nargs == 2'h0);
  wire        n1      = (nargs == 2'h1);
  wire        n2      = (nargs == 2'h2);
  wire        exec    = (st == ST_EXEC);
  wire [15:0] fa_zero = 16'(33'(RAW) - scale(17'(fa_ref), mult));
  wire [15:0] kn_zero = 16'(33'(RAW) - scale(arg0, mult));
  wire [32:0] bg_scal = scale(17'(bg_ref), mult);
  wire        do_fair = (cmd == CMD_FAIR) && n0 && !sleep;
  wire        do_nitr = (cmd == CMD_NITR) && n0 && !sleep;
  wire        do_frce = (cmd == CMD_FRCE) && n1 && !sleep && (arg0 <= ZERO_MAX);
  wire        do_knwn = (cmd == CMD_KNWN) && n1 && !sleep;
  wire        idx_ok  = (arg0 >= IDX_BG_HI) && (arg0 <= IDX_FA_LO);
  wire        do_parm = (cmd == CMD_PARM) && n2 && idx_ok && (arg1 <= BYTE_MAX);
  wire        az_rng  = (arg0 >= AZ_MIN) && (arg0 <= AZ_MAX)
                        && (arg1 >= AZ_MIN) && (arg1 <= AZ_MAX);
  wire        do_azq  = (cmd == CMD_AZI) && n0;
  wire        do_azof = (cmd == CMD_AZI) && n1 && !tok0 && (arg0 == 17'h0_0000);
  wire        do_azon = (cmd == CMD_AZI) && n2 && tok0 && tok1 && az_rng;
  wire        do_alts = (cmd == CMD_ALTS) && n1 && (arg0 <= VAL_MAX);
  wire        do_altq = (cmd == CMD_ALTQ) && n0;
  wire        do_zero = do_fair || do_nitr || do_frce || do_knwn;
  wire        any_ok  = do_zero || do_parm || do_azq || do_azof || do_azon
                        || do_alts || do_altq;
  wire        load    = exec && any_ok;

  wire [15:0] next_zero = do_fair ? fa_zero :
                          do_nitr ? RAW :
                          do_frce ? arg0[15:0] : kn_zero;

  gzc_reply_t reply;
  always_comb begin
    reply = '{cmd: cmd, nf: 2'h1, fmt: FMT_PAD5, f0: 17'(next_zero), f1: arg1};
    if (do_parm || do_alts) begin
      reply.f0 = arg0;
      reply.nf = do_parm ? 2'h2 : 2'h1;
    end else if (do_altq) begin
      reply.f0 = alt;
    end else if (do_azof || (do_azq && !AZ_ENABLE)) begin
      reply.fmt = FMT_ZERO;
    end else if (do_azq || do_azon) begin
      reply.nf = 2'h2;
      reply.fmt = FMT_TENTHS;
      reply.f0 = do_azon ? arg0 : 17'(az_init);
      reply.f1 = do_azon ? arg1 : 17'(az_reg);
    end
  end

  // parser state
  always_comb begin
    next_st = st;
    case (st)
      ST_CMD: begin
        if (rx_take && RX_DATA != CH_CR && RX_DATA != CH_LF) begin
          next_st = ST_ARGS;
        end
      end
      ST_ARGS: begin
        if (rx_take && RX_DATA == CH_CR) begin
          next_st = ST_LF;
        end else if (rx_take && RX_DATA == CH_LF) begin
          next_st = ST_CMD;
        end
      end
      ST_LF: begin
        if (rx_take) begin
          next_st = (RX_DATA == CH_LF && !err) ? ST_EXEC : ST_CMD;
        end
      end
      ST_EXEC: begin
        next_st = load ? ST_WAIT : ST_CMD;
      end
      ST_WAIT: begin
        if (!tx_busy) begin
          next_st = ST_CMD;
        end
      end
      default: begin
        next_st = ST_CMD;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st <= ST_CMD;
      RX_READY <= 1'b0;
    end else begin
      st <= next_st;
      RX_READY <= (next_st == ST_CMD) || (next_st == ST_ARGS) || (next_st == ST_LF);
    end
  end

  // field accumulation
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || (rx_take && st == ST_CMD)) begin
      cmd <= RSTN ? RX_DATA : 8'h00;
      nargs <= 2'h0;
      acc <= 17'h0_0000;
      in_num <= 1'b0;
      dot <= 1'b0;
      frac <= 2'h0;
      err <= 1'b0;
      arg0 <= 17'h0_0000;
      arg1 <= 17'h0_0000;
      tok0 <= 1'b0;
      tok1 <= 1'b0;
    end else if (rx_take && st == ST_ARGS) begin
      if (bad_byte || (RX_DATA == CH_DOT && (dot || !in_num))) begin
        err <= 1'b1;
      end
      if (is_digit) begin
        acc <= acc_wide[16:0];
        in_num <= 1'b1;
        if (acc_wide > 21'(VAL_MAX)) begin
          err <= 1'b1;
        end
        if (dot && frac != 2'h3) begin
          frac <= frac + 2'h1;
        end
      end else if (RX_DATA == CH_DOT) begin
        dot <= 1'b1;
      end else if (close_f) begin
        if (n0) begin
          arg0 <= acc;
          tok0 <= tenth_ok;
        end else begin
          arg1 <= acc;
          tok1 <= tenth_ok;
        end
        if (n2) begin
          err <= 1'b1;
        end else begin
          nargs <= nargs + 2'h1;
        end
        acc <= 17'h0_0000;
        in_num <= 1'b0;
        dot <= 1'b0;
        frac <= 2'h0;
      end
    end
  end

  // settings updated by commands
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      ZERO_POINT <= 16'h0000;
      bg_ref <= REF_DEF;
      fa_ref <= REF_DEF;
      alt <= ALT_DEF;
      AZ_ENABLE <= 1'b1;
      az_init <= AZ_INIT_DEF;
      az_reg <= AZ_REG_DEF;
    end else if (exec) begin
      if (do_zero) begin
        ZERO_POINT <= next_zero;
      end
      if (do_parm) begin
        // high byte carries the 256s, low byte the remainder
        case (arg0[1:0])
          2'h0: bg_ref[15:8] <= arg1[7:0];
          2'h1: bg_ref[7:0] <= arg1[7:0];
          2'h2: fa_ref[15:8] <= arg1[7:0];
          default: fa_ref[7:0] <= arg1[7:0];
        endcase
      end
      if (do_alts) begin
        alt <= arg0;
      end
      if (do_azof) begin
        AZ_ENABLE <= 1'b0;
      end else if (do_azon) begin
        AZ_ENABLE <= 1'b1;
        az_init <= arg0[8:0];
        az_reg <= arg1[8:0];
      end
    end
  end

  gzc_reply_tx u_reply (
    .clk      (CLK_SYS),
    .rstn     (RSTN),
    .load     (load),
    .reply    (reply),
    .tx_ready (TX_READY),
    .busy     (tx_busy),
    .tx_data  (TX_DATA),
    .tx_valid (TX_VALID)
  );

  // wishbone slave: one wait state, unmapped reads return zero
  wire        wb_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire        wb_wr   = wb_req && WB_WE_I;
  wire [31:0] rd_data = (WB_ADR_I == REG_CTRL) ? 32'(sleep) :
                        (WB_ADR_I == REG_MULT) ? 32'(mult) :
                        (WB_ADR_I == REG_ZERO) ? 32'(ZERO_POINT) :
                        (WB_ADR_I == REG_AZ)   ? {AZ_ENABLE, 6'h00, az_reg, 7'h00, az_init} :
                        (WB_ADR_I == REG_ALT)  ? 32'(alt) :
                        (WB_ADR_I == REG_REFS) ? {fa_ref, bg_ref} :
                        (WB_ADR_I == REG_BGSC) ? bg_scal[31:0] : 32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      sleep <= 1'b0;
      mult <= MULT_DEF;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_data : 32'h0000_0000;
      if (wb_wr && WB_ADR_I == REG_CTRL && WB_SEL_I[0]) begin
        sleep <= WB_DAT_I[CTRL_SLEEP_BIT];
      end
      if (wb_wr && WB_ADR_I == REG_MULT) begin
        if (WB_SEL_I[0]) mult[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) mult[15:8] <= WB_DAT_I[15:8];
      end
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  property p_crlf;
    (rx_take && st == ST_LF && RX_DATA == CH_LF && !err) |=> exec;
  endproperty
  a_crlf: assert property (p_crlf) else $error("lf after cr did not execute");

  property p_fair;
    (exec && do_fair) |=> ZERO_POINT == $past(fa_zero);
  endproperty
  a_fair: assert property (p_fair) else $error("fresh-air zero wrong");

  property p_nitr;
    (exec && do_nitr) |=> ZERO_POINT == $past(RAW);
  endproperty
  a_nitr: assert property (p_nitr) else $error("nitrogen zero wrong");

  property p_frce;
    (exec && do_frce) |=> ZERO_POINT == $past(arg0[15:0]) && TX_DATA == CMD_FRCE;
  endproperty
  a_frce: assert property (p_frce) else $error("forced zero wrong");

  property p_sleep;
    (exec && sleep && (cmd == CMD_NITR || cmd == CMD_FAIR)) |=> $stable(ZERO_POINT) && !tx_busy;
  endproperty
  a_sleep: assert property (p_sleep) else $error("zero altered in sleep");

  property p_alt;
    (exec && do_alts) |=> alt == $past(arg0) [*2];
  endproperty
  a_alt: assert property (p_alt) else $error("altitude not stored");

  property p_azoff;
    (exec && do_azof) |=> !AZ_ENABLE;
  endproperty
  a_azoff: assert property (p_azoff) else $error("auto-zero not disabled");

  property p_reply;
    load |=> TX_VALID && tx_busy && TX_DATA == $past(cmd);
  endproperty
  a_reply: assert property (p_reply) else $error("reply did not start");

  property p_bghi;
    (exec && do_parm && arg0 == IDX_BG_HI) |=> bg_ref[15:8] == $past(arg1[7:0]);
  endproperty
  a_bghi: assert property (p_bghi) else $error("high byte not stored");

  c_fair:  cover property (exec && do_fair);
  c_azq:   cover property (exec && do_azq && AZ_ENABLE);
  c_parm:  cover property (exec && do_parm);
  c_done:  cover property (tx_busy ##1 !tx_busy);
endmodule : gzc_cmd_core

// ==== test/gzc_host_model.sv ====
// host-side model: sends command lines on the byte stream, gathers reply lines
// assumes the device takes a byte on valid and ready and offers replies the same way
module gzc_host_model (
  input  wire logic       clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  bit    slow  = 1'b0;
  string reply = "";
  initial begin
    rx_data  = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b1;
  end
  // slow host holds reply ready low on every other clock
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) reply = $sformatf("%s%c", reply, tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic run(input string s, output string r);
    string l;
    int    n;
    l     = {s, "\r\n"};
    reply = "";
    @(posedge clk);
    // each byte holds until the edge at which ready is seen high
    for (int i = 0; i < l.len(); i++) begin
      rx_data  <= l[i];
      rx_valid <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (rx_ready !== 1'b1 && n < 300);
    end
    rx_valid <= 1'b0;
    // released line shows the inverse so stale data never looks valid
    rx_data  <= ~rx_data;
    n = 0;
    while (n < 300 && !(reply.len() > 0 && reply[reply.len()-1] == 8'h0A)) begin
      @(posedge clk);
      n++;
    end
    r = reply;
  endtask : run
endmodule : gzc_host_model

// ==== test/gzc_cmd_core_tb_top.sv ====
// self-checking bench for the zero-calibration command block
// assumes the host model on the byte streams; this module is the wishbone master
module gzc_cmd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gzc_pkg::*;
  typedef struct {
    string       c;
    string       e;
    bit          zc;
    logic [15:0] z;
  } gzc_row_t;
  logic        clk_sys, rstn, cyc, stb, we, ack, az_en;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  adr, rx_data, tx_data;
  logic [31:0] dat_i, dat_o, q;
  logic [15:0] raw, zero_pt;
  int          n_errors = 0;
  int          checks   = 0;
  gzc_row_t    rows[18] = '{
    '{"s", "s 08192", 0, 16'h0000},
    '{"@", "@ 1.0 8.0", 0, 16'h0000},
    '{"U", "U 05000", 1, 16'h1388},
    '{"u 32767", "u 32767", 1, 16'h7FFF},
    '{"P 10 7", "P 00010 00007", 0, 16'h0000},
    '{"P 11 208", "P 00011 00208", 0, 16'h0000},
    '{"G", "G 03000", 1, 16'h0BB8},
    '{"X 1000", "X 04000", 1, 16'h0FA0},
    '{"P 8 1", "P 00008 00001", 0, 16'h0000},
    '{"P 9 144", "P 00009 00144", 0, 16'h0000},
    '{"@ 0.1 37.9", "@ 0.1 37.9", 0, 16'h0000},
    '{"@ 0", "@ 0", 0, 16'h0000},
    '{"@", "@ 0", 0, 16'h0000},
    '{"S 65536", "S 65536", 0, 16'h0000},
    '{"S 0", "S 00000", 0, 16'h0000},
    '{"S 65537", "", 0, 16'h0000},
    '{"Q", "", 0, 16'h0000},
    '{"u 65536", "", 1, 16'h0FA0}
  };

  gzc_cmd_core dut (
    .CLK_SYS (clk_sys), .RSTN (rstn), .WB_CYC_I (cyc), .WB_STB_I (stb), .WB_WE_I (we),
    .WB_ADR_I (adr), .WB_SEL_I (4'hF), .WB_DAT_I (dat_i), .WB_DAT_O (dat_o),
    .WB_ACK_O (ack), .RAW (raw), .RX_DATA (rx_data), .RX_VALID (rx_valid),
    .RX_READY (rx_ready), .TX_DATA (tx_data), .TX_VALID (tx_valid),
    .TX_READY (tx_ready), .ZERO_POINT (zero_pt), .AZ_ENABLE (az_en)
  );
  gzc_host_model host (
    .clk (clk_sys), .rx_data (rx_data), .rx_valid (rx_valid), .rx_ready (rx_ready),
    .tx_data (tx_data), .tx_valid (tx_valid), .tx_ready (tx_ready)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic cmd(input string c, input string e);
    string r;
    host.run(c, r);
    checks++;
    if (r != (e.len() > 0 ? {e, "\r\n"} : "")) begin
      n_errors++;
      $display("[FAIL] %0t reply to '%s' was '%s'", $time, c, r);
    end
  endtask : cmd

  // single classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    dat_i <= d;
    n = 0;
    // ack and read data are taken at the rising edge that sees ack high
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001, "ack timeout");
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    chk(q, e, $sformatf("read %h", a));
  endtask : rd

  task automatic do_reset;
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : do_reset

  initial begin
    repeat (100000) @(posedge clk_sys);
    chk(32'h0000_0000, 32'h0000_0001, "run timeout");
    finish_test();
  end

  initial begin
    rstn  = 1'b0;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    dat_i = 32'h0000_0000;
    raw   = 16'h1388;
    do_reset();
    foreach (rows[i]) begin
      cmd(rows[i].c, rows[i].e);
      if (rows[i].zc) chk({16'h0000, zero_pt}, {16'h0000, rows[i].z}, rows[i].c);
    end
    chk({31'h0, az_en}, 32'h0000_0000, "az off");
    $display("table rows done");
    rd(REG_REFS, 32'h07D0_0190);
    rd(REG_ZERO, 32'h0000_0FA0);
    $display("reference assembly done");
    wb(1'b1, REG_MULT, 32'h0000_0002);
    rd(REG_BGSC, 32'h0000_0320);
    cmd("X 1000", "X 03000");
    cmd("G", "G 01000");
    $display("multiplier done");
    wb(1'b1, REG_CTRL, 32'h0000_0001);
    cmd("U", "");
    chk({16'h0000, zero_pt}, 32'h0000_03E8, "sleep zero");
    cmd("P 8 1", "P 00008 00001");
    wb(1'b1, REG_CTRL, 32'h0000_0000);
    $display("sleep done");
    cmd("@ 2 3.0", "");
    cmd("@ 2.5 3.0", "@ 2.5 3.0");
    rd(REG_AZ, 32'h801E_0019);
    chk({31'h0, az_en}, 32'h0000_0001, "az on");
    $display("interval done");
    host.slow = 1'b1;
    cmd("s", "s 00000");
    host.slow = 1'b0;
    $display("slow host done");
    rd(8'h1C, 32'h0000_0000);
    wb(1'b1, REG_ZERO, 32'h0000_1234);
    rd(REG_ZERO, 32'h0000_03E8);
    $display("bus edges done");
    do_reset();
    chk({16'h0000, zero_pt}, 32'h0000_0000, "zero after reset");
    chk({31'h0, az_en}, 32'h0000_0001, "az after reset");
    rd(REG_AZ, 32'h8050_000A);
    rd(REG_ALT, 32'h0000_2000);
    rd(REG_REFS, 32'h0190_0190);
    rd(REG_MULT, 32'h0000_0001);
    cmd("s", "s 08192");
    $display("second reset done");
    finish_test();
  end
endmodule : gzc_cmd_core_tb_top
